// ### smbus_clk_pkg.sv
package smbus_clk_pkg;
  // Register byte offsets on the register bus.
  localparam logic [4:0] OFF_CLOCK = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_CONTROL = 5'h08;
  localparam logic [4:0] OFF_IRQ_ST = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  // Clock register fields.
  localparam int BIT_SOFT_RST = 7;
  localparam int BIT_HALVE = 2;
  localparam int BIT_GATE_ON = 1;
  localparam logic [7:0] CLOCK_RESET = 8'h00;
  // Status register fields.
  localparam int BIT_PENDING = 7;
  localparam int BIT_TIMEOUT = 6;
  localparam int BIT_IDLE = 1;
  localparam int BIT_GEN_CLK = 0;
  // Control register fields.
  localparam int BIT_TIMEOUT_IRQ_ENABLE = 4;
  localparam int BIT_CLK_DRIVE = 2;
  localparam int BIT_MUX_CLK = 1;
  localparam int BIT_MUX_DATA = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Interrupt status and mask fields.
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_IDLE = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  // Timing figures and derived cycle counts.
  localparam int CLK_HZ = 125000000;
  localparam int CLK_MHZ = 125;
  localparam int SCL_FULL_HZ = 100000;
  localparam int TIMEOUT_US = 25000;
  localparam int THIGH_MAX_US = 50;
  localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_FULL_HZ);
  localparam int TIMEOUT_CYC_DEF = TIMEOUT_US * CLK_MHZ;
  localparam int IDLE_CYC_DEF = THIGH_MAX_US * CLK_MHZ;
  // Bus clock generator phases, Gray coded.
  typedef enum logic [1:0] {
    SCL_OFF = 2'b00,
    SCL_HIGH = 2'b01,
    SCL_LOW = 2'b11
  } scl_state_t;
  // An open-drain pin as driven by the block.
  typedef struct packed {
    logic o;
    logic oe_n;
  } od_pin_t;
  // Avalon request bundle.
  typedef struct packed {
    logic [4:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_t;
endpackage

// ### smbus_clock_and_timeout.sv
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module smbus_clock_and_timeout #(
  parameter int TIMEOUT_CYC = smbus_clk_pkg::TIMEOUT_CYC_DEF,
  parameter int IDLE_CYC = smbus_clk_pkg::IDLE_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire smbus_clk_pkg::avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  input wire logic i_bus_data_pin,
  output smbus_clk_pkg::od_pin_t o_bus_data_pin,
  input wire logic i_bus_clock_pin,
  output smbus_clk_pkg::od_pin_t o_bus_clock_pin,
  input wire logic i_smb_data_drive_low,
  output logic o_gpio_shared_data,
  input wire smbus_clk_pkg::od_pin_t i_gpio_shared_data,
  output logic o_gpio_shared_clock,
  input wire smbus_clk_pkg::od_pin_t i_gpio_shared_clock
);
  localparam logic [21:0] TO_LAST = 22'(TIMEOUT_CYC - 1);
  localparam logic [21:0] IDLE_LAST = 22'(IDLE_CYC - 1);
  localparam logic [9:0] HALF_LAST = 10'(smbus_clk_pkg::SCL_HALF_CYC - 1);

  logic [7:0] clock_reg;
  logic [7:0] control_reg;
  logic [smbus_clk_pkg::IRQ_W-1:0] irq_st;
  logic [smbus_clk_pkg::IRQ_W-1:0] irq_mask;
  logic timeout_error_flag;
  logic pending;
  logic idle;
  logic rst;
  logic gate_on;
  logic halve;
  logic timeout_irq_enable;
  logic in_tick;
  logic halve_ph;
  logic [9:0] half_cnt;
  smbus_clk_pkg::scl_state_t scl_state;
  logic gen_clk;
  logic bus_scl;
  logic bus_sda;
  logic sda_q;
  logic scl_q;
  logic start_ev;
  logic [21:0] low_cnt;
  logic [21:0] high_cnt;
  logic to_ev;
  logic idle_ev;
  logic ack;
  logic req;
  logic wr_hit;
  logic rd_done;
  logic release_wr;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Soft reset holds everything but the clock register, the Avalon handshake flop and the read data flop in reset.
  // soft reset merge
  assign rst = i_sys_rst | clock_reg[smbus_clk_pkg::BIT_SOFT_RST];
  assign gate_on = clock_reg[smbus_clk_pkg::BIT_GATE_ON];
  assign halve = clock_reg[smbus_clk_pkg::BIT_HALVE];
  assign timeout_irq_enable = control_reg[smbus_clk_pkg::BIT_TIMEOUT_IRQ_ENABLE];

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: every access waits one cycle, so read data come from a flop.
  assign req = i_avs.read | i_avs.write;
  assign o_avs_waitrequest = req & ~ack;
  assign wr_hit = i_avs.write & ack & i_avs.byteenable[0];
  assign rd_done = i_avs.read & ack;
  assign release_wr = wr_hit & (i_avs.address == smbus_clk_pkg::OFF_STATUS)
    & i_avs.writedata[smbus_clk_pkg::BIT_PENDING];

  // The handshake flop clears under system reset only, so a soft reset
  // written mid-access still lets the master finish.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (i_avs.address == smbus_clk_pkg::OFF_CLOCK) begin
      rd_byte = clock_reg;
    end else if (i_avs.address == smbus_clk_pkg::OFF_STATUS) begin
      rd_byte[smbus_clk_pkg::BIT_PENDING] = pending;
      rd_byte[smbus_clk_pkg::BIT_TIMEOUT] = timeout_error_flag;
      rd_byte[smbus_clk_pkg::BIT_IDLE] = idle;
      rd_byte[smbus_clk_pkg::BIT_GEN_CLK] = gen_clk;
    end else if (i_avs.address == smbus_clk_pkg::OFF_CONTROL) begin
      rd_byte = control_reg;
    end else if (i_avs.address == smbus_clk_pkg::OFF_IRQ_ST) begin
      rd_byte = {5'h00, irq_st};
    end else if (i_avs.address == smbus_clk_pkg::OFF_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask};
    end
  end

  // Read data are captured on the first edge and stand at the completing edge.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs.read & ~ack) begin
      o_avs_readdata <= {24'h000000, rd_byte};
    end
  end

  // Clock register: only the system reset clears it, so the soft reset bit
  // stays until software writes it back to zero.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clock_reg <= smbus_clk_pkg::CLOCK_RESET;
    end else if (wr_hit && i_avs.address == smbus_clk_pkg::OFF_CLOCK) begin
      clock_reg <= i_avs.writedata[7:0] & 8'h86;
    end
  end

  // Control and mask registers.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      control_reg <= smbus_clk_pkg::CONTROL_RESET;
      irq_mask <= smbus_clk_pkg::IRQ_RESET;
    end else if (wr_hit && i_avs.address == smbus_clk_pkg::OFF_CONTROL) begin
      control_reg <= i_avs.writedata[7:0] & 8'h17;
    end else if (wr_hit && i_avs.address == smbus_clk_pkg::OFF_IRQ_MASK) begin
      irq_mask <= i_avs.writedata[smbus_clk_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input clock: a gated enable, thinned to every other cycle when halved.
  // gate input clock
  always_ff @(posedge i_clk) begin
    if (rst || !gate_on) begin
      halve_ph <= 1'b0;
    end else begin
      halve_ph <= halve ? ~halve_ph : 1'b0;
    end
  end
  assign in_tick = gate_on & (~halve | halve_ph);

  // Bus clock generator; each half period is a fixed count of input ticks.
  // select bus rate
  always_ff @(posedge i_clk) begin
    if (rst || !gate_on) begin
      scl_state <= smbus_clk_pkg::SCL_OFF;
      half_cnt <= 10'h000;
    end else if (in_tick) begin
      case (scl_state)
        smbus_clk_pkg::SCL_OFF: begin
          scl_state <= smbus_clk_pkg::SCL_HIGH;
          half_cnt <= 10'h000;
        end
        default: begin
          half_cnt <= (half_cnt == HALF_LAST) ? 10'h000 : half_cnt + 10'h001;
          if (half_cnt == HALF_LAST) begin
            scl_state <= (scl_state == smbus_clk_pkg::SCL_HIGH) ?
              smbus_clk_pkg::SCL_LOW : smbus_clk_pkg::SCL_HIGH;
          end
        end
      endcase
    end
  end
  assign gen_clk = (scl_state != smbus_clk_pkg::SCL_LOW);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sharing. A pin not given to the bus reads as a released (high) line.
  // pin multiplexing
  always_comb begin
    if (control_reg[smbus_clk_pkg::BIT_MUX_DATA]) begin
      o_bus_data_pin.o = 1'b0;
      o_bus_data_pin.oe_n = ~i_smb_data_drive_low;
    end else begin
      o_bus_data_pin = i_gpio_shared_data;
    end
    if (control_reg[smbus_clk_pkg::BIT_MUX_CLK]) begin
      o_bus_clock_pin.o = 1'b0;
      o_bus_clock_pin.oe_n = ~(control_reg[smbus_clk_pkg::BIT_CLK_DRIVE] & ~gen_clk);
    end else begin
      o_bus_clock_pin = i_gpio_shared_clock;
    end
  end
  assign o_gpio_shared_data = i_bus_data_pin;
  assign o_gpio_shared_clock = i_bus_clock_pin;
  assign bus_sda = ~control_reg[smbus_clk_pkg::BIT_MUX_DATA] | i_bus_data_pin;
  assign bus_scl = ~control_reg[smbus_clk_pkg::BIT_MUX_CLK] | i_bus_clock_pin;

  ////////////////////////////////////////////////////////////////////////////////
  // Line history for start detection; sampled every cycle, far above bus rate.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      sda_q <= 1'b1;
      scl_q <= 1'b1;
    end else begin
      sda_q <= bus_sda;
      scl_q <= bus_scl;
    end
  end
  assign start_ev = gate_on & sda_q & ~bus_sda & scl_q & bus_scl;

  // Low-period counter; it only runs while the input clock is gated on.
  // low period count
  always_ff @(posedge i_clk) begin
    if (rst || bus_scl) begin
      low_cnt <= 22'h000000;
    end else if (gate_on && low_cnt <= TO_LAST) begin
      low_cnt <= low_cnt + 22'h000001;
    end
  end
  assign to_ev = gate_on & ~bus_scl & (low_cnt == TO_LAST);

  // High-period counter for idle; a stopped clock is simply an idle bus,
  // no minimum clock rate is checked.
  // no idle minimum
  always_ff @(posedge i_clk) begin
    if (rst || !(bus_scl && bus_sda)) begin
      high_cnt <= 22'h000000;
    end else if (high_cnt <= IDLE_LAST) begin
      high_cnt <= high_cnt + 22'h000001;
    end
  end
  assign idle_ev = bus_scl & bus_sda & (high_cnt == IDLE_LAST);
  always_ff @(posedge i_clk) begin
    if (rst || !(bus_scl && bus_sda)) begin
      idle <= 1'b0;
    end else if (idle_ev) begin
      idle <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timeout flag and pending. Release of pending clears the flag, but a new
  // timeout in the same cycle wins.
  // pending and release
  always_ff @(posedge i_clk) begin
    if (rst) begin
      timeout_error_flag <= 1'b0;
      pending <= 1'b0;
    end else begin
      timeout_error_flag <= to_ev | (timeout_error_flag & ~release_wr);
      pending <= (to_ev & timeout_irq_enable) | (pending & ~release_wr);
    end
  end

  // Sticky interrupt status, cleared by reading it; a new event wins.
  always_ff @(posedge i_clk) begin
    if (rst) begin
      irq_st <= smbus_clk_pkg::IRQ_RESET;
    end else begin
      irq_st <= {idle_ev, start_ev, to_ev} | ((rd_done &&
        i_avs.address == smbus_clk_pkg::OFF_IRQ_ST) ? 3'h0 : irq_st);
    end
  end
  assign o_irq = (|(irq_st & irq_mask)) | pending;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);

  property p_halve_off;
    gate_on && !halve |-> in_tick;
  endproperty
  a_halve_off: assert property (p_halve_off) else $error("input clock not full rate");
  property p_halve_on;
    (gate_on && halve && in_tick) ##1 (gate_on && halve) |-> !in_tick;
  endproperty
  a_halve_on: assert property (p_halve_on) else $error("halved clock too fast");
  property p_gate;
    !gate_on |-> !in_tick ##1 (scl_state == smbus_clk_pkg::SCL_OFF || !gate_on);
  endproperty
  a_gate: assert property (p_gate) else $error("input clock ran while gated off");
  property p_rate;
    $changed(gen_clk) && $past(gate_on) && $past(scl_state) != smbus_clk_pkg::SCL_OFF |->
      $past(half_cnt) == HALF_LAST;
  endproperty
  a_rate: assert property (p_rate) else $error("bus clock half period wrong");
  property p_timeout;
    to_ev |=> timeout_error_flag && irq_st[smbus_clk_pkg::IRQ_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");
  property p_idle;
    !(bus_scl && bus_sda) |=> !idle;
  endproperty
  a_idle: assert property (p_idle) else $error("idle while a line is low");
  property p_start;
    start_ev |=> irq_st[smbus_clk_pkg::IRQ_START];
  endproperty
  a_start: assert property (p_start) else $error("start not recorded");
  property p_mux;
    !control_reg[smbus_clk_pkg::BIT_MUX_DATA] |-> o_bus_data_pin == i_gpio_shared_data;
  endproperty
  a_mux: assert property (p_mux) else $error("data pin not given to gpio");
  property p_pend;
    to_ev && timeout_irq_enable |=> pending && o_irq;
  endproperty
  a_pend: assert property (p_pend) else $error("pending not raised");
  property p_flag_clr;
    $fell(pending) |-> !timeout_error_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag kept after release");
  property p_srst;
    @(posedge i_clk) disable iff (i_sys_rst)
      clock_reg[smbus_clk_pkg::BIT_SOFT_RST] |=> !timeout_error_flag && !pending && irq_st == 3'h0;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset did not clear");
  property p_cnt;
    bus_scl |=> low_cnt == 22'h000000;
  endproperty
  a_cnt: assert property (p_cnt) else $error("low count not restarted");
  c_timeout: cover property (to_ev && timeout_irq_enable);
  c_slow: cover property (halve && $rose(gen_clk));
  c_idle: cover property (idle_ev);
  c_start: cover property (start_ev);
endmodule

// ### smbus_bus_partner.sv
`timescale 1ns/1ps
// Another device on the bus: it may stretch the clock or pull data low.
module smbus_bus_partner (
  input wire logic i_clk,
  input wire logic i_hold_clk,
  input wire logic i_pull_data,
  output logic o_clk_oe_n,
  output logic o_data_oe_n
);
  // clock stretch
  // Registered so the line only moves just after an edge.
  always_ff @(posedge i_clk) begin
    o_clk_oe_n <= ~i_hold_clk;
  end
  // data pull
  // A released line goes to the pull-up level, never a held old value.
  always_ff @(posedge i_clk) begin
    o_data_oe_n <= ~i_pull_data;
  end
endmodule

// ### smbus_clock_and_timeout_tb.sv
`timescale 1ns/1ps
module smbus_clock_and_timeout_tb;
  // Timeout kept above the longest generator low phase so clocking never trips it.
  localparam int TO_CYC = 2000;
  localparam int ID_CYC = 20;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  smbus_clk_pkg::avs_req_t avs = '0;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  smbus_clk_pkg::od_pin_t dpin;
  smbus_clk_pkg::od_pin_t cpin;
  smbus_clk_pkg::od_pin_t gdat = 2'h3;
  smbus_clk_pkg::od_pin_t gclk = 2'h3;
  logic gdat_lvl;
  logic gclk_lvl;
  logic drive_low = 1'b0;
  logic hold_clk = 1'b0;
  logic pull_data = 1'b0;
  logic p_clk_oe_n;
  logic p_dat_oe_n;
  logic [7:0] rd;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  // Open-drain lines with pull-ups: low if any party drives low.
  wire clk_line = !((cpin.oe_n === 1'b0 && cpin.o === 1'b0) || p_clk_oe_n === 1'b0);
  wire dat_line = !((dpin.oe_n === 1'b0 && dpin.o === 1'b0) || p_dat_oe_n === 1'b0);

  always #4 i_clk = ~i_clk;

  smbus_clock_and_timeout #(.TIMEOUT_CYC(TO_CYC), .IDLE_CYC(ID_CYC)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq), .i_bus_data_pin(dat_line),
    .o_bus_data_pin(dpin), .i_bus_clock_pin(clk_line), .o_bus_clock_pin(cpin),
    .i_smb_data_drive_low(drive_low), .o_gpio_shared_data(gdat_lvl),
    .i_gpio_shared_data(gdat), .o_gpio_shared_clock(gclk_lvl),
    .i_gpio_shared_clock(gclk));

  smbus_bus_partner part_u (.i_clk(i_clk), .i_hold_clk(hold_clk),
    .i_pull_data(pull_data), .o_clk_oe_n(p_clk_oe_n), .o_data_oe_n(p_dat_oe_n));

  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge i_clk);
    avs <= '{address: a, read: ~wr, write: wr, byteenable: be, writedata: {24'h0, d}};
    @(posedge i_clk);
    while (wreq !== 1'b0) @(posedge i_clk);
    rd = rdata[7:0];
    avs <= '0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdm(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(32'(rd & m), 32'(e));
  endtask

  // Cycles until the next falling edge of the driven clock pin, 0 if none.
  task automatic find_fall(output int c);
    logic prev;
    prev = cpin.oe_n;
    c = 0;
    while (c < 3000) begin
      @(posedge i_clk);
      c++;
      if (prev === 1'b1 && cpin.oe_n === 1'b0) break;
      prev = cpin.oe_n;
    end
    if (c >= 3000) c = 0;
  endtask

  function automatic int exp_period(logic gate, logic halve);
    return gate ? (halve ? 4 : 2) * smbus_clk_pkg::SCL_HALF_CYC : 0;
  endfunction

  // Cuts a hang short well above the expected run length.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 90000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic m;
    void'($urandom(32'h8191709e));
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdm(smbus_clk_pkg::OFF_CLOCK, 8'hFF, 8'h00);
    rdm(smbus_clk_pkg::OFF_CONTROL, 8'hFF, 8'h00);
    wr(5'h14, 8'hFF);
    rdm(5'h14, 8'hFF, 8'h00);
    bus(1'b1, smbus_clk_pkg::OFF_IRQ_MASK, 8'h07, 4'hE);
    rdm(smbus_clk_pkg::OFF_IRQ_MASK, 8'hFF, 8'h00);
    // Pin sharing: GPIO drive passes when unmuxed, bus drive on the data pin when muxed.
    for (int i = 0; i < 8; i++) begin
      m = 1'($urandom);
      wr(smbus_clk_pkg::OFF_CONTROL, {7'h0, m});
      gdat <= 2'($urandom);
      gclk <= 2'($urandom);
      drive_low <= 1'($urandom);
      @(negedge i_clk);
      chk(32'(dpin), m ? {30'h0, 1'b0, ~drive_low} : 32'(gdat));
      chk(32'(cpin), 32'(gclk));
      chk(32'(gdat_lvl), 32'(dat_line));
      chk(32'(gclk_lvl), 32'(clk_line));
    end
    gdat <= 2'h3;
    gclk <= 2'h3;
    drive_low <= 1'b0;
    // Every gate and halve combination, period measured on the pin.
    wr(smbus_clk_pkg::OFF_CONTROL, 8'h07);
    for (int g = 0; g < 4; g++) begin
      wr(smbus_clk_pkg::OFF_CLOCK, {5'h0, g[1], g[0], 1'b0});
      repeat (3) find_fall(n);
      chk(32'(n), 32'(exp_period(g[0], g[1])));
    end
    // Clock stretch just short of the limit, then past it.
    wr(smbus_clk_pkg::OFF_CLOCK, 8'h02);
    wr(smbus_clk_pkg::OFF_CONTROL, 8'h13);
    rdm(smbus_clk_pkg::OFF_IRQ_ST, 8'h07, 8'h04);
    hold_clk <= 1'b1;
    repeat (TO_CYC - 20) @(posedge i_clk);
    hold_clk <= 1'b0;
    rdm(smbus_clk_pkg::OFF_STATUS, 8'hC0, 8'h00);
    hold_clk <= 1'b1;
    repeat (TO_CYC + 20) @(posedge i_clk);
    hold_clk <= 1'b0;
    rdm(smbus_clk_pkg::OFF_STATUS, 8'hC0, 8'hC0);
    chk(32'(irq), 32'h1);
    wr(smbus_clk_pkg::OFF_STATUS, 8'h80);
    rdm(smbus_clk_pkg::OFF_STATUS, 8'hC0, 8'h00);
    chk(32'(irq), 32'h0);
    wr(smbus_clk_pkg::OFF_IRQ_MASK, 8'h01);
    @(negedge i_clk);
    chk(32'(irq), 32'h1);
    rdm(smbus_clk_pkg::OFF_IRQ_ST, 8'h01, 8'h01);
    @(negedge i_clk);
    chk(32'(irq), 32'h0);
    rdm(smbus_clk_pkg::OFF_IRQ_ST, 8'h01, 8'h00);
    // Idle after both lines high, then a start from the partner.
    repeat (ID_CYC + 5) @(posedge i_clk);
    rdm(smbus_clk_pkg::OFF_STATUS, 8'h02, 8'h02);
    pull_data <= 1'b1;
    repeat (4) @(posedge i_clk);
    rdm(smbus_clk_pkg::OFF_STATUS, 8'h02, 8'h00);
    pull_data <= 1'b0;
    rdm(smbus_clk_pkg::OFF_IRQ_ST, 8'h02, 8'h02);
    // Soft reset holds other registers cleared and does not self-clear.
    wr(smbus_clk_pkg::OFF_CLOCK, 8'h82);
    rdm(smbus_clk_pkg::OFF_CLOCK, 8'hFF, 8'h82);
    rdm(smbus_clk_pkg::OFF_CONTROL, 8'hFF, 8'h00);
    rdm(smbus_clk_pkg::OFF_IRQ_MASK, 8'hFF, 8'h00);
    wr(smbus_clk_pkg::OFF_CLOCK, 8'h00);
    rdm(smbus_clk_pkg::OFF_CLOCK, 8'hFF, 8'h00);
    close_out();
  end
endmodule
